//--- core/pin_cell.sv
`timescale 1ns/10ps
// one general purpose pin: input synchroniser and registered pad drive
module pin_cell (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // pad side
   input  wire logic pad_in,
   output logic      pad_out,
   output logic      pad_oe,
   output logic      pad_pull,
   output logic      pin_sync,
   // configuration
   input  wire logic latch,
   input  wire logic dir,
   input  wire logic od,
   input  wire logic pull,
   input  wire logic alt_en,
   input  wire logic alt_val,
   input  wire logic alt_oe,
   input  wire logic stop_mode
);

   logic sync1_ff;    // first stage, read only by sync2_ff
   logic sync2_ff;    // settled pin level
   logic out_ff;      // pad output level
   logic oe_ff;       // pad output enable
   logic pull_ff;     // pull-up enable

   // alternate function takes over value and enable when selected
   wire drive_val = alt_en ? alt_val : latch;
   wire drive_en  = alt_en ? alt_oe : dir;
   // open drain only ever pulls low, a one releases the pin
   wire nxt_oe    = drive_en & ~(od & drive_val);
   wire nxt_out   = drive_val & ~od;
   // pull-up only acts while the pad is not driven
   wire nxt_pull  = pull & ~nxt_oe;

   // two stage synchroniser for the asynchronous pad
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else begin
         sync1_ff <= pad_in;
         sync2_ff <= sync1_ff;
      end
   end

   // pad drive; held in stop so the pin keeps its last state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_ff  <= 1'b0;
         oe_ff   <= 1'b0;
         pull_ff <= 1'b0;
      end else if (!stop_mode) begin
         out_ff  <= nxt_out;
         oe_ff   <= nxt_oe;
         pull_ff <= nxt_pull;
      end
   end

   assign pad_out  = out_ff;
   assign pad_oe   = oe_ff;
   assign pad_pull = pull_ff;
   assign pin_sync = sync2_ff;

endmodule : pin_cell

//--- core/port_pin_mux.sv
`timescale 1ns/10ps
// port and alternate function pin multiplexer with ahb-lite registers
module port_pin_mux
   import port_pin_mux_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // general purpose pads, 0-7 port_a, 8-15 port_b, 16-19 port_c,
   // 20-23 port_d
   input  wire logic [23:0] pin_in,
   output logic [23:0]      pin_out,
   output logic [23:0]      pin_oe,
   output logic [23:0]      pin_pull_en,
   output logic [7:0]       schmitt_en,
   output logic [3:0]       analog_in_en,
   // power control
   input  wire logic        stop_mode,
   // peripheral side of the alternate functions
   output logic             ext_irq_in_0,
   output logic             ext_irq_in_1,
   output logic             ext_irq_in_2,
   output logic             event_count_in,
   input  wire logic        tone_out_src,
   input  wire logic        sclk_src,
   input  wire logic        sclk_src_oe,
   output logic             sclk_in,
   input  wire logic        sdo_src,
   output logic             sdi_in,
   output logic [7:0]       key_scan_in,
   input  wire logic        pwm_src,
   // shared lcd pins, index 0..2 = common 1..3 / segment 36..34
   input  wire logic [2:0]  lcd_common_out_src,
   input  wire logic [2:0]  lcd_segment_out_src,
   output logic [2:0]       lcd_shared_out,
   output logic [2:0]       lcd_shared_is_com
);

   // port configuration, flat over all 24 pins
   logic [23:0] data_ff;            // output latches
   logic [23:0] dir_ff;             // 1 = output
   logic [23:0] pull_ff;            // pull-up enables
   logic [23:0] od_ff;              // open-drain enables
   logic [7:0]  schmitt_ff;         // port_b schmitt input select
   logic [7:0]  alt_ff;             // alternate function enables
   logic [1:0]  duty_ff;            // lcd_duty_select field
   logic [2:0]  lcd_out_ff;         // shared lcd pin drive
   logic [2:0]  lcd_com_ff;         // shared pin acts as common

   // bus pipeline
   logic [7:0]  addr_ff;            // data phase byte address
   logic        hi_ok_ff;           // upper address bits were zero
   logic        wr_pend_ff;         // write data phase in progress
   logic        rd_pend_ff;         // read data phase in progress
   logic        hreadyout_ff;
   logic [31:0] hrdata_ff;

   // per pin signals
   logic [23:0] pin_sync;           // synchronised pad levels
   logic [23:0] alt_en;             // pin handed to its peripheral
   logic [23:0] alt_val;            // peripheral drive value
   logic [23:0] alt_oe;             // peripheral drive enable
   logic [31:0] rd_val;             // read mux result

   // address phase taken when selected, non-idle and bus ready
   wire         take     = hsel & htrans[1] & hready;
   wire [1:0]   sel_port = addr_ff[5:4];
   wire [1:0]   sel_fld  = addr_ff[3:2];
   wire         in_ports = hi_ok_ff & (addr_ff[7:6] == 2'h0);
   wire [4:0]   plsb     = port_lsb(sel_port);
   wire [23:0]  pmask    = port_mask(sel_port);
   wire [23:0]  wd_vec   = 24'(hwdata << plsb);

   // write strobes, valid in the write data phase
   wire wr_port  = wr_pend_ff & in_ports;
   wire wr_data  = wr_port & (sel_fld == FLD_DATA);
   wire wr_dir   = wr_port & (sel_fld == FLD_DIR);
   wire wr_pull  = wr_port & (sel_fld == FLD_PULL);
   wire wr_od    = wr_port & (sel_fld == FLD_OD);
   wire wr_other = wr_pend_ff & hi_ok_ff;
   wire wr_sch   = wr_other & (addr_ff == OFS_SCHMITT);
   wire wr_alt   = wr_other & (addr_ff == OFS_ALT_ENABLE);
   wire wr_lcr   = wr_other & (addr_ff == OFS_LCD_CONTROL_REG);

   // a port write replaces only that port's bits
   wire [23:0] nxt_data = (data_ff & ~pmask) | (wd_vec & pmask);
   wire [23:0] nxt_dir  = (dir_ff & ~pmask) | (wd_vec & pmask);
   wire [23:0] nxt_pull = (pull_ff & ~pmask) | (wd_vec & pmask);
   wire [23:0] nxt_od   = (od_ff & ~pmask) | (wd_vec & pmask);

   // analog pins have their digital input ignored
   wire [23:0] an_mask  = 24'({alt_ff[ALT_AN_LSB +: 4], 16'h0000});
   wire [23:0] pin_view = pin_sync & ~an_mask;
   // outputs read back their latch, inputs the pin
   wire [23:0] data_rd  = (dir_ff & data_ff) | (~dir_ff & pin_view);

   // field chosen by the port address
   wire [23:0] fld_vec  = (sel_fld == FLD_DATA) ? data_rd :
                          (sel_fld == FLD_DIR)  ? dir_ff  :
                          (sel_fld == FLD_PULL) ? pull_ff : od_ff;
   wire [31:0] port_rd  = 32'((fld_vec & pmask) >> plsb);

   // a shared lcd pin is a common while the duty needs that common
   wire [2:0] nxt_com;
   genvar s;
   generate
      for (s = 0; s < NUM_SHARED; s++) begin : g_shared
         assign nxt_com[s] = (duty_ff > 2'(s));
      end
   endgenerate
   wire [2:0] nxt_lcd = (nxt_com & lcd_common_out_src) |
                        (~nxt_com & lcd_segment_out_src);

   // read mux, decoded from the registered data phase address
   always_comb begin
      if (!hi_ok_ff) begin
         rd_val = 32'h00000000;
      end else if (in_ports) begin
         rd_val = port_rd;
      end else if (addr_ff == OFS_SCHMITT) begin
         rd_val = {24'h000000, schmitt_ff};
      end else if (addr_ff == OFS_ALT_ENABLE) begin
         rd_val = {24'h000000, alt_ff};
      end else if (addr_ff == OFS_LCD_CONTROL_REG) begin
         rd_val = {30'h00000000, duty_ff};
      end else if (addr_ff == OFS_STATUS) begin
         rd_val = {28'h0000000, lcd_com_ff, stop_mode};
      end else begin
         rd_val = 32'h00000000;                  // unmapped reads zero
      end
   end

   // alternate function routing; pins without one keep plain port use
   always_comb begin
      alt_en  = 24'h000000;
      alt_val = 24'h000000;
      alt_oe  = 24'h000000;
      alt_en[PIN_TONE]  = alt_ff[ALT_TONE];
      alt_val[PIN_TONE] = tone_out_src;
      alt_oe[PIN_TONE]  = 1'b1;
      alt_en[PIN_SCLK]  = alt_ff[ALT_SCLK];
      alt_val[PIN_SCLK] = sclk_src;
      alt_oe[PIN_SCLK]  = sclk_src_oe;
      alt_en[PIN_SDO]   = alt_ff[ALT_SDO];
      alt_val[PIN_SDO]  = sdo_src;
      alt_oe[PIN_SDO]   = 1'b1;
      alt_en[PIN_PWM]   = alt_ff[ALT_PWM];
      alt_val[PIN_PWM]  = pwm_src;
      alt_oe[PIN_PWM]   = 1'b1;
   end

   // address phase capture; reads add one wait state so a write just
   // ahead of them is already visible
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_ff      <= 8'h00;
         hi_ok_ff     <= 1'b0;
         wr_pend_ff   <= 1'b0;
         rd_pend_ff   <= 1'b0;
         hreadyout_ff <= 1'b1;
      end else begin
         if (take) begin
            addr_ff  <= haddr[7:0];
            hi_ok_ff <= (haddr[31:8] == 24'h000000);
         end
         wr_pend_ff   <= take & hwrite;
         rd_pend_ff   <= take & ~hwrite;
         hreadyout_ff <= ~(take & ~hwrite);
      end
   end

   // read data registered at the end of the wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h00000000;
      end else if (rd_pend_ff) begin
         hrdata_ff <= rd_val;
      end
   end

   // port configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_ff <= RST_PORT_VEC;
         dir_ff  <= RST_PORT_VEC;               // all pins input
         pull_ff <= RST_PORT_VEC;
         od_ff   <= RST_PORT_VEC;
      end else begin
         if (wr_data) data_ff <= nxt_data;
         if (wr_dir)  dir_ff  <= nxt_dir;
         if (wr_pull) pull_ff <= nxt_pull;
         if (wr_od)   od_ff   <= nxt_od;
      end
   end

   // mode registers; hsize is ignored since only words are used
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         schmitt_ff <= RST_SCHMITT;
         alt_ff     <= RST_ALT;
         duty_ff    <= RST_DUTY;                // commons at reset
      end else begin
         if (wr_sch) schmitt_ff <= hwdata[7:0];
         if (wr_alt) alt_ff     <= hwdata[7:0];
         if (wr_lcr) duty_ff    <= hwdata[1:0];
      end
   end

   // shared lcd pins, frozen in stop like the ports
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lcd_out_ff <= 3'h0;
         lcd_com_ff <= 3'h7;
      end else if (!stop_mode) begin
         lcd_out_ff <= nxt_lcd;
         lcd_com_ff <= nxt_com;
      end
   end

   // one cell per general purpose pin
   genvar i;
   generate
      for (i = 0; i < NUM_PINS; i++) begin : g_pin
         pin_cell u_cell (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .pad_in    (pin_in[i]),
            .pad_out   (pin_out[i]),
            .pad_oe    (pin_oe[i]),
            .pad_pull  (pin_pull_en[i]),
            .pin_sync  (pin_sync[i]),
            .latch     (data_ff[i]),
            .dir       (dir_ff[i]),
            .od        (od_ff[i]),
            .pull      (pull_ff[i]),
            .alt_en    (alt_en[i]),
            .alt_val   (alt_val[i]),
            .alt_oe    (alt_oe[i]),
            .stop_mode (stop_mode)
         );
      end
   endgenerate

   // peripheral inputs straight from the synchroniser flops
   assign ext_irq_in_0   = pin_sync[PIN_IRQ0];
   assign ext_irq_in_1   = pin_sync[PIN_IRQ1];
   assign ext_irq_in_2   = pin_sync[PIN_IRQ2];
   assign event_count_in = pin_sync[PIN_EVENT];
   assign sclk_in        = pin_sync[PIN_SCLK];
   assign sdi_in         = pin_sync[PIN_SDI];
   assign key_scan_in    = pin_sync[LSB_PORT_B +: 8];
   assign analog_in_en   = alt_ff[ALT_AN_LSB +: 4];
   // schmitt only meaningful on input pins, pad takes the select
   assign schmitt_en     = schmitt_ff;

   // bus and shared lcd outputs
   assign hreadyout         = hreadyout_ff;
   assign hresp             = 1'b0;
   assign hrdata            = hrdata_ff;
   assign lcd_shared_out    = lcd_out_ff;
   assign lcd_shared_is_com = lcd_com_ff;

endmodule : port_pin_mux

//--- include/port_pin_mux_pkg.sv
// Operation
// - direction bit 1 drives pin, 0 inputs
// - per-pin pull-up and open-drain on every port
// - port_b pins: output, input or schmitt input
// - port_a carries irq, counter, tone, serial pins
// - port_b pins are key_scan_in 0 to 7
// - port_c pins are analog_in channels 0 to 3
// - port_d bit 1 alone carries pwm output
// - shared lcd pins: duty picks common or segment
// - stop freezes lcd and port pin outputs
package port_pin_mux_pkg;

   // pin numbering across the flat 24-bit pin vectors
   localparam int          NUM_PINS     = 24;
   localparam int          NUM_SHARED   = 3;
   localparam logic [4:0]  LSB_PORT_A   = 5'h00;
   localparam logic [4:0]  LSB_PORT_B   = 5'h08;
   localparam logic [4:0]  LSB_PORT_C   = 5'h10;
   localparam logic [4:0]  LSB_PORT_D   = 5'h14;
   localparam logic [23:0] MASK_PORT_A  = 24'h0000ff;
   localparam logic [23:0] MASK_PORT_B  = 24'h00ff00;
   localparam logic [23:0] MASK_PORT_C  = 24'h0f0000;
   localparam logic [23:0] MASK_PORT_D  = 24'hf00000;

   // alternate function pin positions
   localparam int PIN_IRQ0  = 0;
   localparam int PIN_IRQ1  = 1;
   localparam int PIN_IRQ2  = 2;
   localparam int PIN_EVENT = 3;
   localparam int PIN_TONE  = 4;
   localparam int PIN_SCLK  = 5;
   localparam int PIN_SDO   = 6;
   localparam int PIN_SDI   = 7;
   localparam int PIN_PWM   = 21;

   // register byte offsets; port block is stride 16, four fields each
   localparam logic [1:0] PORT_A   = 2'h0;
   localparam logic [1:0] PORT_B   = 2'h1;
   localparam logic [1:0] PORT_C   = 2'h2;
   localparam logic [1:0] FLD_DATA = 2'h0;
   localparam logic [1:0] FLD_DIR  = 2'h1;
   localparam logic [1:0] FLD_PULL = 2'h2;
   localparam logic [1:0] FLD_OD   = 2'h3;
   localparam logic [7:0] OFS_SCHMITT          = 8'h40;
   localparam logic [7:0] OFS_ALT_ENABLE       = 8'h44;
   localparam logic [7:0] OFS_LCD_CONTROL_REG  = 8'h48;
   localparam logic [7:0] OFS_STATUS           = 8'h4c;

   // alternate enable register fields
   localparam int ALT_TONE   = 0;
   localparam int ALT_SCLK   = 1;
   localparam int ALT_SDO    = 2;
   localparam int ALT_PWM    = 3;
   localparam int ALT_AN_LSB = 4;

   // status register fields
   localparam int ST_STOP    = 0;
   localparam int ST_COM_LSB = 1;

   // reset values
   localparam logic [23:0] RST_PORT_VEC = 24'h000000;
   localparam logic [7:0]  RST_SCHMITT  = 8'h00;
   localparam logic [7:0]  RST_ALT      = 8'h00;
   localparam logic [1:0]  RST_DUTY     = 2'h3;

   // base bit of a port inside the flat pin vectors
   function automatic logic [4:0] port_lsb(input logic [1:0] p);
      if (p == PORT_A) port_lsb = LSB_PORT_A;
      else if (p == PORT_B) port_lsb = LSB_PORT_B;
      else if (p == PORT_C) port_lsb = LSB_PORT_C;
      else port_lsb = LSB_PORT_D;
   endfunction : port_lsb

   // pins of a port inside the flat pin vectors
   function automatic logic [23:0] port_mask(input logic [1:0] p);
      if (p == PORT_A) port_mask = MASK_PORT_A;
      else if (p == PORT_B) port_mask = MASK_PORT_B;
      else if (p == PORT_C) port_mask = MASK_PORT_C;
      else port_mask = MASK_PORT_D;
   endfunction : port_mask

endpackage : port_pin_mux_pkg

//--- verif/board_model.sv
`timescale 1ns/10ps
// board side of the pads: resolves each wire from all its drivers
module board_model (
   // clock
   input  logic        hclk,
   // device pad drive
   input  logic [23:0] pin_out,
   input  logic [23:0] pin_oe,
   input  logic [23:0] pin_pull_en,
   // board drivers on released pads
   input  logic [23:0] ext_val,
   input  logic [23:0] ext_en,
   // resolved wire levels
   output logic [23:0] pin_in
);
   logic [23:0] float_ff; // open pads wander, never hold a level
   initial float_ff = 24'h5a5a5a;
   // toggles so a stale value can never pass as driven
   always @(posedge hclk) float_ff <= ~float_ff;
   // pad first, then board, then pull-up, else noise
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pin_pull_en | float_ff));
endmodule : board_model

//--- verif/port_pin_mux_props.sv
`timescale 1ns/10ps
// bus, pad and lcd relations seen at the top ports
module port_pin_mux_props (
   // clock and reset
   input logic        hclk,
   input logic        hresetn,
   // bus
   input logic        hsel,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic        hready,
   input logic        hreadyout,
   // pads
   input logic [23:0] pin_in,
   input logic [23:0] pin_out,
   input logic [23:0] pin_oe,
   input logic [23:0] pin_pull_en,
   input logic        stop_mode,
   // peripheral side
   input logic        ext_irq_in_0,
   input logic        ext_irq_in_1,
   input logic        ext_irq_in_2,
   input logic        event_count_in,
   input logic        sclk_in,
   input logic        sdi_in,
   input logic [7:0]  key_scan_in,
   // shared lcd pins
   input logic [2:0]  lcd_common_out_src,
   input logic [2:0]  lcd_segment_out_src,
   input logic [2:0]  lcd_shared_out,
   input logic [2:0]  lcd_shared_is_com
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // a transfer is taken at this edge
   wire take = hsel && htrans[1] && hready;
   property p_rd_wait;
      take && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait)
      else $error("read wait state not one cycle");
   property p_wr_zero;
      take && hwrite |=> hreadyout;
   endproperty
   a_wr_zero: assert property (p_wr_zero)
      else $error("write stalled the bus");
   // stop sampled high freezes every pad and lcd drive
   property p_stop_hold;
      stop_mode |=> $stable(pin_out) && $stable(pin_oe)
         && $stable(pin_pull_en) && $stable(lcd_shared_out);
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("pad drive moved during stop");
   // a driven pad never also has its pull-up on
   property p_pull_oe;
      (pin_pull_en & pin_oe) == 24'h000000;
   endproperty
   a_pull_oe: assert property (p_pull_oe)
      else $error("pull-up enabled on a driven pad");
   // guarded so the synchroniser has two edges out of reset
   property p_irq_sync;
      $past(hresetn, 2) && $past(hresetn) |-> {sdi_in, sclk_in,
         event_count_in, ext_irq_in_2, ext_irq_in_1, ext_irq_in_0}
         == $past({pin_in[7], pin_in[5], pin_in[3:0]}, 2);
   endproperty
   a_irq_sync: assert property (p_irq_sync)
      else $error("port_a inputs misrouted");
   property p_keys;
      $past(hresetn, 2) && $past(hresetn) |->
         key_scan_in == $past(pin_in[15:8], 2);
   endproperty
   a_keys: assert property (p_keys)
      else $error("key scan inputs misrouted");
   property p_com_therm;
      lcd_shared_is_com inside {3'h0, 3'h1, 3'h3, 3'h7};
   endproperty
   a_com_therm: assert property (p_com_therm)
      else $error("common pin selection not contiguous");
   // skipped while the selection itself is changing
   property p_lcd_mux;
      !stop_mode |=> !$stable(lcd_shared_is_com) || lcd_shared_out ==
         ((lcd_shared_is_com & $past(lcd_common_out_src))
         | (~lcd_shared_is_com & $past(lcd_segment_out_src)));
   endproperty
   a_lcd_mux: assert property (p_lcd_mux)
      else $error("shared lcd pin drives wrong source");
   c_read: cover property (take && !hwrite);
   c_stop: cover property (stop_mode ##1 stop_mode);
   c_static: cover property (lcd_shared_is_com == 3'h0);
endmodule : port_pin_mux_props

bind port_pin_mux port_pin_mux_props i_port_pin_mux_props (
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
   .pin_in, .pin_out, .pin_oe, .pin_pull_en, .stop_mode,
   .ext_irq_in_0, .ext_irq_in_1, .ext_irq_in_2, .event_count_in,
   .sclk_in, .sdi_in, .key_scan_in, .lcd_common_out_src,
   .lcd_segment_out_src, .lcd_shared_out, .lcd_shared_is_com);

//--- verif/port_pin_mux_test.sv
`timescale 1ns/10ps
// register level checks of the port and alternate function mux
module port_pin_mux_test;
   import port_pin_mux_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, stop_mode;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [23:0] pin_in, pin_out, pin_oe, pin_pull_en, ext_val, ext_en;
   logic [7:0]  schmitt_en, key_scan_in;
   logic [3:0]  analog_in_en;
   logic        hreadyout, hresp, tone, sclk, sclk_oe, sdo, pwm;
   logic [2:0]  com_src, seg_src, lcd_out, is_com, e, el;
   int          n_fail, n_checks;
   wire         hready = hreadyout; // single slave closes the bus
   port_pin_mux i_port_pin_mux (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout,
      .hresp, .hrdata, .pin_in, .pin_out, .pin_oe, .pin_pull_en,
      .schmitt_en, .analog_in_en, .stop_mode, .ext_irq_in_0(),
      .ext_irq_in_1(), .ext_irq_in_2(), .event_count_in(),
      .tone_out_src(tone), .sclk_src(sclk), .sclk_src_oe(sclk_oe),
      .sclk_in(), .sdo_src(sdo), .sdi_in(), .key_scan_in,
      .pwm_src(pwm), .lcd_common_out_src(com_src),
      .lcd_segment_out_src(seg_src), .lcd_shared_out(lcd_out),
      .lcd_shared_is_com(is_com));
   board_model i_board_model (.hclk, .pin_out, .pin_oe, .pin_pull_en,
      .ext_val, .ext_en, .pin_in);
   always #25 hclk = ~hclk;
   // compare and count
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         $display("Error %s expected %h seen %h", n, x, g);
         n_fail++;
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge hclk);
   endtask : tick
   // one single write; the master holds each phase until ready
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask : wr
   // one single read; data taken at the closing edge
   task rdt(input logic [7:0] a);
      @(posedge hclk);
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : rdt
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // reset state of lcd selection and pads
   task t_reset;
      rdt(OFS_LCD_CONTROL_REG);
      chk("duty", 32'h3, rd);
      rdt(OFS_STATUS);
      chk("status", 32'he, rd);
      chk("oe", 32'h0, {8'h00, pin_oe});
   endtask : t_reset
   // direction and data read mix on port_a
   task t_dir;
      wr({PORT_A, FLD_DATA, 2'h0}, 32'ha5);
      wr({PORT_A, FLD_DIR, 2'h0}, 32'h0f);
      tick(3);
      chk("a_oe", 32'h0f, {24'h0, pin_oe[7:0]});
      // pad value follows the latch even where the enable is off
      chk("a_out", 32'ha5, {24'h0, pin_out[7:0]});
      rdt({PORT_A, FLD_DATA, 2'h0});
      chk("a_data", 32'h35, rd);
   endtask : t_dir
   // pull-up and open drain on port_b, keys through the same pads
   task t_pull;
      wr({PORT_B, FLD_DATA, 2'h0}, 32'h05);
      wr({PORT_B, FLD_DIR, 2'h0}, 32'h0f);
      wr({PORT_B, FLD_PULL, 2'h0}, 32'hff);
      wr({PORT_B, FLD_OD, 2'h0}, 32'h03);
      tick(3);
      chk("b_oe", 32'h0e, {24'h0, pin_oe[15:8]});
      chk("b_out", 32'h04, {24'h0, pin_out[15:8]});
      chk("b_pull", 32'hf1, {24'h0, pin_pull_en[15:8]});
      chk("keys", 32'(ext_val[15:12]), 32'(key_scan_in[7:4]));
   endtask : t_pull
   task t_schmitt;
      wr(OFS_SCHMITT, 32'h5a);
      tick(2);
      chk("schmitt", 32'h5a, {24'h0, schmitt_en});
      rdt(OFS_SCHMITT);
      chk("schmitt_rd", 32'h5a, rd);
   endtask : t_schmitt
   // every alternate output, then the tone and pwm sources dropped
   task t_alt;
      wr(OFS_ALT_ENABLE, 32'hff);
      tick(2);
      chk("alt_oe", 32'h7, {29'h0, pin_oe[6:4]});
      chk("alt_out", 32'h7, {29'h0, pin_out[6:4]});
      chk("d_oe", 32'h2, {28'h0, pin_oe[23:20]});
      chk("analog", 32'hf, {28'h0, analog_in_en});
      tone <= 1'b0;
      pwm <= 1'b0;
      tick(2);
      chk("tone", 32'h0, {31'h0, pin_out[4]});
      chk("pwm", 32'h0, {31'h0, pin_out[21]});
      rdt({PORT_C, FLD_DATA, 2'h0});
      chk("c_data", 32'h0, rd);
   endtask : t_alt
   // each duty code against the selection of the shared pins
   task t_lcd;
      for (int d = 0; d < 4; d++) begin
         wr(OFS_LCD_CONTROL_REG, d);
         tick(2);
         for (int s = 0; s < 3; s++) e[s] = (d > s);
         el = (com_src & e) | (seg_src & ~e);
         chk("is_com", {29'h0, e}, {29'h0, is_com});
         chk("lcd", {29'h0, el}, {29'h0, lcd_out});
      end
   endtask : t_lcd
   // writes during stop complete; the pads follow once stop drops
   task t_stop;
      stop_mode <= 1'b1;
      com_src <= 3'h2;
      wr({PORT_A, FLD_DATA, 2'h0}, 32'hff);
      tick(2);
      // bits 4 to 6 stay with tone, clock and data out
      chk("stop_out", 32'he5, {24'h0, pin_out[7:0]});
      chk("stop_lcd", 32'h5, {29'h0, lcd_out});
      rdt(OFS_STATUS);
      chk("stop_st", 32'h1, rd & 32'h1);
      stop_mode <= 1'b0;
      tick(3);
      chk("wake_out", 32'hef, {24'h0, pin_out[7:0]});
      chk("wake_lcd", 32'h2, {29'h0, lcd_out});
      rdt(8'h80);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : t_stop
   initial begin
      hclk = 0;
      hresetn = 0;
      {hsel, hwrite, stop_mode, htrans, haddr, hwdata} = '0;
      hsel = 1'b1;
      {tone, sclk, sclk_oe, sdo, pwm} = 5'h1f;
      {com_src, seg_src} = 6'h2a;
      ext_val = 24'h0c963c;
      ext_en = 24'hffffff;
      n_fail = 0;
      n_checks = 0;
      tick(10);
      hresetn <= 1'b1;
      t_reset;
      t_dir;
      t_pull;
      t_schmitt;
      t_alt;
      t_lcd;
      t_stop;
      close_out;
   end
   // a hang cuts the run short as a mismatch
   initial begin
      #200000;
      n_fail++;
      close_out;
   end
endmodule : port_pin_mux_test
